// *** rtl/signal_mixer.sv ***
// Data signal mixer: modulator and carrier selection, sync gating, output pin
// Overview of operation
// RULE_01: Setting the enable bit in the control register activates the mixer.
// RULE_02: Enable clear forces both carriers to ground, modulator to software bit.
// RULE_03: Clearing enable keeps stored selections; they apply again when set.
// RULE_04: Output disabled: mixing continues but the output pin is held low.
// RULE_05: Modulator selector offers fifteen sources including software bit.
// RULE_06: Four-bit source select field picks the modulator input.
// RULE_07: Each carrier selector offers fifteen sources including ground.
// RULE_08: Carrier high source comes from a four-bit field in its register.
// RULE_09: Carrier low source comes from a four-bit field in its register.
// RULE_10: Leaving a synced carrier: other active at once, synced runs to fall.
// RULE_11: Returning to synced carrier: drop other now, wait for its falling edge.
// RULE_12: Carrier high and low each have their own sync bit.
// RULE_13: Output follows carrier high when modulator high, else carrier low.
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
module signal_mixer
   import signal_mixer_pkg::*;
(
   input  wire logic       mclk_in,
   input  wire logic       nrst_in,
   // Avalon-MM slave
   input  wire logic [3:0] avs_address_in,
   input  wire logic       avs_read_in,
   input  wire logic       avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0] avs_byteenable_in,
   output logic [31:0]     avs_readdata_out,
   output logic            avs_waitrequest_out,
   // On-chip sources, same clock domain
   input  wire logic       capture_compare_one_in,
   input  wire logic       capture_compare_two_in,
   input  wire logic       pulse_width_output_five_in,
   input  wire logic       pulse_width_output_six_in,
   input  wire logic       serial_port_data_out_in,
   input  wire logic       comparator_one_in,
   input  wire logic       comparator_two_in,
   input  wire logic       serial_transceiver_tx_in,
   input  wire logic       numeric_oscillator_in,
   input  wire logic [3:0] logic_cell_in,
   input  wire logic       high_freq_internal_oscillator_in,
   input  wire logic       reference_clock_output_in,
   // External pins, synchronised here
   input  wire logic       external_modulation_input_in,
   input  wire logic       external_carrier_input_one_in,
   input  wire logic       external_carrier_input_two_in,
   // Mixed output pin
   output logic            mixer_pin_out
);
   import signal_mixer_pkg::*;

   logic [7:0]             mixer_control_reg_r;
   logic [3:0]             modulation_source_select_r;
   logic [3:0]             carrier_high_select_r;
   logic [3:0]             carrier_low_select_r;
   logic                   carrier_high_sync_bit_r;
   logic                   carrier_low_sync_bit_r;
   bus_state_e             bus_state_r;
   logic [2:0]             pin_meta_r;
   logic [2:0]             pin_sync_r;
   logic                   sysclk_toggle_r;
   logic                   mod_sel;
   logic                   car_h_sel;
   logic                   car_l_sel;
   logic                   mod_sig;
   logic                   car_h;
   logic                   car_l;
   logic                   car_h_d_r;
   logic                   car_l_d_r;
   logic                   car_h_fall;
   logic                   car_l_fall;
   logic                   h_gate_r;
   logic                   l_gate_r;
   logic                   h_gate_nxt;
   logic                   l_gate_nxt;
   logic                   mixed;
   logic                   mixer_enable_bit;
   logic                   software_modulation_bit;
   logic                   output_enable_bit;
   logic                   wr_hit;
   logic [31:0]            rd_word;

   assign mixer_enable_bit        = mixer_control_reg_r[EN_POS];
   assign output_enable_bit       = mixer_control_reg_r[OUTEN_POS];
   assign software_modulation_bit = mixer_control_reg_r[SWBIT_POS];

   // Two-flop synchronisers for the external pins
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         pin_meta_r <= 3'h0;
         pin_sync_r <= 3'h0;
      end
      else
      begin
         pin_meta_r <= {external_carrier_input_two_in, external_carrier_input_one_in,
                        external_modulation_input_in};
         pin_sync_r <= pin_meta_r;
      end
   end

   // System clock as a carrier: half rate toggle, the fastest a clocked path can show
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         sysclk_toggle_r <= 1'b0;
      else
         sysclk_toggle_r <= ~sysclk_toggle_r;
   end

   // Avalon answer: one wait cycle, ack on the second
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         bus_state_r <= BUS_IDLE;
      else
      begin
         case (bus_state_r)
            BUS_IDLE: if (avs_read_in || avs_write_in) bus_state_r <= BUS_ACK;
            BUS_ACK:  bus_state_r <= BUS_IDLE;
            default:  bus_state_r <= BUS_IDLE;
         endcase
      end
   end

   assign wr_hit = avs_write_in && (bus_state_r == BUS_ACK) && avs_byteenable_in[0];

   // Register writes; enable clear never touches the selections
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         mixer_control_reg_r        <= CTRL_RST;
         modulation_source_select_r <= SEL_RST;
         carrier_high_select_r      <= SEL_RST;
         carrier_low_select_r       <= SEL_RST;
         carrier_high_sync_bit_r    <= 1'b0;
         carrier_low_sync_bit_r     <= 1'b0;
      end
      else if (wr_hit)
      begin
         case (avs_address_in)
            CTRL_OFS: // RULE_01
            begin
               mixer_control_reg_r[EN_POS]    <= avs_writedata_in[EN_POS];
               mixer_control_reg_r[OUTEN_POS] <= avs_writedata_in[OUTEN_POS];
               mixer_control_reg_r[SWBIT_POS] <= avs_writedata_in[SWBIT_POS];
            end
            MSRC_OFS: modulation_source_select_r <= avs_writedata_in[SEL_W-1:0]; // RULE_06
            CARH_OFS: // RULE_08 RULE_12
            begin
               carrier_high_select_r   <= avs_writedata_in[SEL_W-1:0];
               carrier_high_sync_bit_r <= avs_writedata_in[SYNC_POS];
            end
            CARL_OFS: // RULE_09 RULE_12
            begin
               carrier_low_select_r   <= avs_writedata_in[SEL_W-1:0];
               carrier_low_sync_bit_r <= avs_writedata_in[SYNC_POS];
            end
            default: ;
         endcase
      end
   end

   // Read mux; unmapped words read zero
   always_comb
   begin
      rd_word = 32'h0;
      case (avs_address_in)
         CTRL_OFS: rd_word[7:0] = {mixer_control_reg_r[7:6], mixer_pin_out, 4'h0,
                                   mixer_control_reg_r[SWBIT_POS]};
         MSRC_OFS: rd_word[3:0] = modulation_source_select_r;
         CARH_OFS: rd_word[7:0] = {carrier_high_sync_bit_r, 3'h0, carrier_high_select_r};
         CARL_OFS: rd_word[7:0] = {carrier_low_sync_bit_r, 3'h0, carrier_low_select_r};
         default:  rd_word = 32'h0;
      endcase
   end

   // Registered bus outputs
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         avs_readdata_out    <= 32'h0;
         avs_waitrequest_out <= 1'b1;
      end
      else
      begin
         avs_waitrequest_out <= !((avs_read_in || avs_write_in) && bus_state_r == BUS_IDLE);
         if (avs_read_in && bus_state_r == BUS_IDLE)
            avs_readdata_out <= rd_word;
      end
   end

   // Modulator source select
   always_comb
   begin
      case (modulation_source_select_r) // RULE_05 RULE_06
         MOD_CC1:  mod_sel = capture_compare_one_in;
         MOD_CC2:  mod_sel = capture_compare_two_in;
         MOD_PW5:  mod_sel = pulse_width_output_five_in;
         MOD_PW6:  mod_sel = pulse_width_output_six_in;
         MOD_SPI:  mod_sel = serial_port_data_out_in;
         MOD_CMP1: mod_sel = comparator_one_in;
         MOD_CMP2: mod_sel = comparator_two_in;
         MOD_TX:   mod_sel = serial_transceiver_tx_in;
         MOD_PIN:  mod_sel = pin_sync_r[0];
         MOD_NCO:  mod_sel = numeric_oscillator_in;
         MOD_LC1:  mod_sel = logic_cell_in[0];
         MOD_LC2:  mod_sel = logic_cell_in[1];
         MOD_LC3:  mod_sel = logic_cell_in[2];
         MOD_LC4:  mod_sel = logic_cell_in[3];
         default:  mod_sel = software_modulation_bit;
      endcase
   end

   // Shared carrier mux for both carriers
   function automatic logic car_pick(input logic [3:0] sel);
      case (sel) // RULE_07
         CAR_CC1:    car_pick = capture_compare_one_in;
         CAR_CC2:    car_pick = capture_compare_two_in;
         CAR_PW5:    car_pick = pulse_width_output_five_in;
         CAR_PW6:    car_pick = pulse_width_output_six_in;
         CAR_NCO:    car_pick = numeric_oscillator_in;
         CAR_SYSCLK: car_pick = sysclk_toggle_r;
         CAR_HFOSC:  car_pick = high_freq_internal_oscillator_in;
         CAR_LC1:    car_pick = logic_cell_in[0];
         CAR_LC2:    car_pick = logic_cell_in[1];
         CAR_LC3:    car_pick = logic_cell_in[2];
         CAR_LC4:    car_pick = logic_cell_in[3];
         CAR_REFCLK: car_pick = reference_clock_output_in;
         CAR_PIN1:   car_pick = pin_sync_r[1];
         CAR_PIN2:   car_pick = pin_sync_r[2];
         default:    car_pick = 1'b0;
      endcase
   endfunction

   // Picks live in a process: a plain assign would miss source changes inside the function
   always_comb
   begin
      car_h_sel = car_pick(carrier_high_select_r); // RULE_08
      car_l_sel = car_pick(carrier_low_select_r);  // RULE_09
   end

   // Disabled mixer sees grounded carriers and the software bit
   assign mod_sig = mixer_enable_bit ? mod_sel   : software_modulation_bit; // RULE_02 RULE_03
   assign car_h   = mixer_enable_bit ? car_h_sel : 1'b0;                    // RULE_02
   assign car_l   = mixer_enable_bit ? car_l_sel : 1'b0;                    // RULE_02

   // Carrier history for falling-edge detection
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         car_h_d_r <= 1'b0;
         car_l_d_r <= 1'b0;
      end
      else
      begin
         car_h_d_r <= car_h;
         car_l_d_r <= car_l;
      end
   end

   assign car_h_fall = car_h_d_r && !car_h;
   assign car_l_fall = car_l_d_r && !car_l;

   // Gate of each carrier: unsynced follows modulator now, synced changes on a fall
   always_comb
   begin
      h_gate_nxt = mod_sig;
      l_gate_nxt = !mod_sig;
      if (carrier_high_sync_bit_r && car_h_fall == 1'b0) // RULE_10 RULE_11
         h_gate_nxt = h_gate_r;
      if (carrier_low_sync_bit_r && car_l_fall == 1'b0)  // RULE_10 RULE_11
         l_gate_nxt = l_gate_r;
   end

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         h_gate_r <= 1'b0;
         l_gate_r <= 1'b0;
      end
      else
      begin
         h_gate_r <= h_gate_nxt; // RULE_12
         l_gate_r <= l_gate_nxt; // RULE_12
      end
   end

   // Mix: gated carriers; a synced gate only opens after a fall so no cut pulse
   assign mixed = (car_h && (carrier_high_sync_bit_r ? h_gate_r : mod_sig)) ||
                  (car_l && (carrier_low_sync_bit_r ? l_gate_r : !mod_sig)); // RULE_13

   // Pin register; held low while output disabled, mixing carries on
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         mixer_pin_out <= 1'b0;
      else
         mixer_pin_out <= output_enable_bit ? mixed : 1'b0; // RULE_04
   end

endmodule

// *** rtl/signal_mixer_pkg.sv ***
// Package: register map, field layout and source encodings of the signal mixer
package signal_mixer_pkg;

   // Register byte offsets on the Avalon-MM slave (word aligned)
   localparam logic [3:0] CTRL_OFS     = 4'h0;
   localparam logic [3:0] MSRC_OFS     = 4'h4;
   localparam logic [3:0] CARH_OFS     = 4'h8;
   localparam logic [3:0] CARL_OFS     = 4'hc;

   // Control register fields
   localparam int         EN_POS       = 7;
   localparam int         OUTEN_POS    = 6;
   localparam int         OUT_POS      = 5;
   localparam int         SWBIT_POS    = 0;
   // Carrier register fields
   localparam int         SYNC_POS     = 7;
   localparam int         SEL_W        = 4;

   // Reset values
   localparam logic [7:0] CTRL_RST     = 8'h00;
   localparam logic [3:0] SEL_RST      = 4'h0;

   // Modulator source codes
   localparam logic [3:0] MOD_CC1      = 4'h0;
   localparam logic [3:0] MOD_CC2      = 4'h1;
   localparam logic [3:0] MOD_PW5      = 4'h2;
   localparam logic [3:0] MOD_PW6      = 4'h3;
   localparam logic [3:0] MOD_SPI      = 4'h4;
   localparam logic [3:0] MOD_CMP1     = 4'h5;
   localparam logic [3:0] MOD_CMP2     = 4'h6;
   localparam logic [3:0] MOD_TX       = 4'h7;
   localparam logic [3:0] MOD_PIN      = 4'h8;
   localparam logic [3:0] MOD_NCO      = 4'h9;
   localparam logic [3:0] MOD_LC1      = 4'ha;
   localparam logic [3:0] MOD_LC2      = 4'hb;
   localparam logic [3:0] MOD_LC3      = 4'hc;
   localparam logic [3:0] MOD_LC4      = 4'hd;
   localparam logic [3:0] MOD_SWBIT    = 4'he;

   // Carrier source codes
   localparam logic [3:0] CAR_VSS      = 4'h0;
   localparam logic [3:0] CAR_CC1      = 4'h1;
   localparam logic [3:0] CAR_CC2      = 4'h2;
   localparam logic [3:0] CAR_PW5      = 4'h3;
   localparam logic [3:0] CAR_PW6      = 4'h4;
   localparam logic [3:0] CAR_NCO      = 4'h5;
   localparam logic [3:0] CAR_SYSCLK   = 4'h6;
   localparam logic [3:0] CAR_HFOSC    = 4'h7;
   localparam logic [3:0] CAR_LC1      = 4'h8;
   localparam logic [3:0] CAR_LC2      = 4'h9;
   localparam logic [3:0] CAR_LC3      = 4'ha;
   localparam logic [3:0] CAR_LC4      = 4'hb;
   localparam logic [3:0] CAR_REFCLK   = 4'hc;
   localparam logic [3:0] CAR_PIN1     = 4'hd;
   localparam logic [3:0] CAR_PIN2     = 4'he;

   // Bus answer state
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_e;

endpackage

// *** verif/signal_mixer_monitor.sv ***
// Checker: bus handshake, read data and pin relations of the signal mixer
`timescale 1ns/100ps
module signal_mixer_monitor
   import signal_mixer_pkg::*;
(
   input wire logic        mclk_in,
   input wire logic        nrst_in,
   input wire logic [3:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0]  avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   input wire logic        capture_compare_one_in,
   input wire logic        capture_compare_two_in,
   input wire logic        mixer_pin_out
);
   logic [7:0] ctrl_r, carh_r, carl_r;
   logic [3:0] msel_r;
   logic [2:0] age_r;
   logic       wack;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   // Shadow registers; age lets sync and pin flops settle after a write
   assign wack = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         ctrl_r <= 8'h00;
         carh_r <= 8'h00;
         carl_r <= 8'h00;
         msel_r <= 4'h0;
         age_r  <= 3'h0;
      end
      else
      begin
         ctrl_r <= (wack && avs_address_in == CTRL_OFS) ? avs_writedata_in[7:0] : ctrl_r;
         carh_r <= (wack && avs_address_in == CARH_OFS) ? avs_writedata_in[7:0] : carh_r;
         carl_r <= (wack && avs_address_in == CARL_OFS) ? avs_writedata_in[7:0] : carl_r;
         msel_r <= (wack && avs_address_in == MSRC_OFS) ? avs_writedata_in[3:0] : msel_r;
         age_r  <= wack ? 3'h0 : ((age_r == 3'h7) ? age_r : age_r + 3'h1);
      end
   end
   a_ack_two: assert property (
      $rose(avs_read_in || avs_write_in) |=> !avs_waitrequest_out)
      else $error("waitrequest not low one cycle after request");
   a_ack_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");
   a_ack_needs_req: assert property (
      !avs_waitrequest_out |-> avs_read_in || avs_write_in)
      else $error("acknowledge without request");
   a_rdata_hold: assert property ($changed(avs_readdata_out) |-> avs_read_in)
      else $error("read data moved outside a read");
   a_rdata_upper: assert property (
      avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_unmapped_zero: assert property (
      avs_read_in && !avs_waitrequest_out && avs_address_in[1:0] != 2'b00
      |-> avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_outen_low: assert property (!ctrl_r[6] && !$past(ctrl_r[6]) |-> !mixer_pin_out)
      else $error("pin high while output disabled");
   a_mix_off_low: assert property (!ctrl_r[7] && !$past(ctrl_r[7]) |-> !mixer_pin_out)
      else $error("pin high while mixer disabled");
   a_follow_high: assert property (
      age_r > 3'h2 && ctrl_r == 8'hc1 && msel_r == MOD_SWBIT && carh_r == 8'h01
      && !carl_r[7] |-> mixer_pin_out == $past(capture_compare_one_in))
      else $error("pin does not follow high carrier");
   a_follow_low: assert property (
      age_r > 3'h2 && ctrl_r == 8'hc0 && msel_r == MOD_SWBIT && carl_r == 8'h02
      && !carh_r[7] |-> mixer_pin_out == $past(capture_compare_two_in))
      else $error("pin does not follow low carrier");
endmodule
bind signal_mixer signal_mixer_monitor mon (.*);

// *** verif/signal_sources.sv ***
// Partner model: on-chip peripheral outputs and external pins feeding the mixer
`timescale 1ns/100ps
module signal_sources (
   input  wire logic        clk_in,
   input  wire logic [17:0] lvl_in,
   output logic      [17:0] src_out = 18'h0
);
   // Sources move just after an edge, as real peripheral outputs do
   always @(posedge clk_in)
   begin
      src_out <= lvl_in;
   end
endmodule

// *** verif/tb_top.sv ***
// Testbench: register tasks and directed scenarios for the signal mixer
`timescale 1ns/100ps
module tb_top;
   import signal_mixer_pkg::*;
   logic        mclk_in = 1'b0;
   logic        nrst_in = 1'b0;
   logic [3:0]  avs_address_in = 4'h0;
   logic        avs_read_in = 1'b0;
   logic        avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [3:0]  avs_byteenable_in = 4'hf;
   logic [31:0] avs_readdata_out, got;
   logic        avs_waitrequest_out, mixer_pin_out;
   logic [17:0] lvl = 18'h0;
   logic [17:0] src;
   logic [4:0]  cmap [16];
   int          checks = 0;
   int          n_mismatch = 0;
   int          cyc = 0;
   signal_sources srcs (.clk_in(mclk_in), .lvl_in(lvl), .src_out(src));
   signal_mixer uut (.*,
      .capture_compare_one_in(src[0]), .capture_compare_two_in(src[1]),
      .pulse_width_output_five_in(src[2]), .pulse_width_output_six_in(src[3]),
      .serial_port_data_out_in(src[4]), .comparator_one_in(src[5]),
      .comparator_two_in(src[6]), .serial_transceiver_tx_in(src[7]),
      .external_modulation_input_in(src[8]), .numeric_oscillator_in(src[9]),
      .logic_cell_in(src[13:10]), .high_freq_internal_oscillator_in(src[14]),
      .reference_clock_output_in(src[15]), .external_carrier_input_one_in(src[16]),
      .external_carrier_input_two_in(src[17]));
   always #5 mclk_in = ~mclk_in;
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One transfer, held until waitrequest is sampled low; the timeout ends a hang
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      avs_write_in <= w;
      avs_read_in <= !w;
      avs_address_in <= a;
      avs_writedata_in <= d;
      do
         @(posedge mclk_in);
      while (avs_waitrequest_out !== 1'b0);
      got = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(got, exp, "readdata");
   endtask
   // Waits out partner flop, pin synchronisers and the output flop
   task automatic pin(input logic exp);
      repeat (6) @(posedge mclk_in);
      chk({31'h0, mixer_pin_out}, {31'h0, exp}, "pin");
   endtask
   initial
   begin
      cmap = '{5'd31, 5'd0, 5'd1, 5'd2, 5'd3, 5'd9, 5'd30, 5'd14,
               5'd10, 5'd11, 5'd12, 5'd13, 5'd15, 5'd16, 5'd17, 5'd31};
      repeat (10) @(posedge mclk_in);
      nrst_in <= 1'b1;
      for (int i = 0; i < 16; i += 4)
         rdc(i[3:0], 32'h0);
      bus(1'b1, 4'h6, 32'hff);
      rdc(4'h6, 32'h0);
      bus(1'b1, CARL_OFS, 32'h85);
      avs_byteenable_in <= 4'he;
      bus(1'b1, CARL_OFS, 32'h03);
      avs_byteenable_in <= 4'hf;
      rdc(CARL_OFS, 32'h85);
      $display("register test done");
      // Each modulator code against a steady high carrier
      bus(1'b1, CARH_OFS, {28'h0, CAR_REFCLK});
      bus(1'b1, CARL_OFS, 32'h0);
      for (int k = 0; k < 16; k++)
      begin
         bus(1'b1, CTRL_OFS, 32'hc0);
         bus(1'b1, MSRC_OFS, k);
         if (k < 14)
            lvl <= 18'h8000 | (18'h1 << k);
         else
            bus(1'b1, CTRL_OFS, 32'hc1);
         pin(1'b1);
         lvl <= 18'h8000;
         bus(1'b1, CTRL_OFS, 32'hc0);
         pin(1'b0);
      end
      $display("modulator test done");
      // Each carrier code on both sides; system clock checked apart
      bus(1'b1, MSRC_OFS, {28'h0, MOD_SWBIT});
      for (int s = 0; s < 2; s++)
         for (int k = 0; k < 16; k += (k == 5) ? 2 : 1)
         begin
            bus(1'b1, CTRL_OFS, 32'hc0 | s);
            bus(1'b1, s ? CARH_OFS : CARL_OFS, k);
            bus(1'b1, s ? CARL_OFS : CARH_OFS, 32'h0);
            lvl <= (cmap[k] == 5'd31) ? '1 : 18'h1 << cmap[k];
            pin(cmap[k] < 5'd30);
            lvl <= 18'h0;
            pin(1'b0);
         end
      bus(1'b1, CARH_OFS, {28'h0, CAR_SYSCLK});
      repeat (6) @(posedge mclk_in);
      got[0] = mixer_pin_out;
      @(posedge mclk_in);
      chk({31'h0, mixer_pin_out}, {31'h0, ~got[0]}, "pin");
      $display("carrier test done");
      bus(1'b1, CARH_OFS, {28'h0, CAR_REFCLK});
      lvl <= 18'h8000;
      bus(1'b1, CTRL_OFS, 32'h41);
      pin(1'b0);
      rdc(CARH_OFS, 32'hc);
      rdc(MSRC_OFS, 32'he);
      bus(1'b1, CTRL_OFS, 32'hc1);
      pin(1'b1);
      rdc(CTRL_OFS, 32'he1);
      bus(1'b1, CTRL_OFS, 32'h81);
      pin(1'b0);
      $display("enable test done");
      // High carrier synchronised, low carrier free running
      bus(1'b1, CARH_OFS, 32'h81);
      bus(1'b1, CARL_OFS, 32'h02);
      lvl <= 18'h3;
      bus(1'b1, CTRL_OFS, 32'hc0);
      pin(1'b1);
      lvl <= 18'h2;
      pin(1'b1);
      lvl <= 18'h3;
      bus(1'b1, CTRL_OFS, 32'hc1);
      pin(1'b0);
      lvl <= 18'h2;
      pin(1'b0);
      lvl <= 18'h3;
      pin(1'b1);
      lvl <= 18'h1;
      bus(1'b1, CTRL_OFS, 32'hc0);
      pin(1'b1);
      lvl <= 18'h0;
      pin(1'b0);
      lvl <= 18'h1;
      pin(1'b0);
      lvl <= 18'h3;
      pin(1'b1);
      // Low carrier synchronised, high carrier free running
      bus(1'b1, CARH_OFS, 32'h01);
      bus(1'b1, CARL_OFS, 32'h82);
      lvl <= 18'h2;
      bus(1'b1, CTRL_OFS, 32'hc1);
      pin(1'b1);
      lvl <= 18'h0;
      pin(1'b0);
      lvl <= 18'h2;
      pin(1'b0);
      lvl <= 18'h3;
      bus(1'b1, CTRL_OFS, 32'hc0);
      pin(1'b0);
      lvl <= 18'h1;
      pin(1'b0);
      lvl <= 18'h2;
      pin(1'b1);
      $display("sync test done");
      print_verdict();
   end
   // Cycle ceiling, well above the roughly 1200 cycles the tests need
   always @(posedge mclk_in)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end
endmodule
